// File: verilog/eeprom_pkg.sv
// shared constants and types of the serial memory slave
package eeprom_pkg;
    localparam int ADDR_W = 16;
    localparam int IDX_W = 7;
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_W = 24;
    localparam logic [7:0] PAGE_BYTES = 8'h80;
    localparam logic [3:0] CTRL_CODE = 4'ha;
    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam logic [3:0] ACK_BIT = 4'h8;
    localparam logic [15:0] PTR_RST = 16'h0000;
    localparam int CLK_PERIOD_PS = 8000;
    localparam int BYTE_WRITE_TIME_US = 100;
    // longest time, so rounded down
    localparam int BYTE_WRITE_CYCLES = (BYTE_WRITE_TIME_US * 1000000) / CLK_PERIOD_PS;
    localparam int TIMER_W = 16;
    typedef enum logic [2:0]
    {
        ST_IDLE = 3'h0,
        ST_CTRL = 3'h1,
        ST_ADDRH = 3'h2,
        ST_ADDRL = 3'h3,
        ST_WDATA = 3'h4,
        ST_RDATA = 3'h5,
        ST_SKIP = 3'h6
    } link_st_t;
endpackage : eeprom_pkg

// File: verilog/prog_fifo.sv
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module prog_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 8
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [PW-1:0] wp_ff, nxt_wp, rp_ff, nxt_rp;
    logic [PW:0] cnt_ff, nxt_cnt;
    logic push, pop;

    assign in_ready_o = (cnt_ff != DEPTH[PW:0]);
    assign out_valid_o = (cnt_ff != '0);
    assign out_data_o = mem_ff[rp_ff];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_comb
    begin
        nxt_wp = push ? PW'(wp_ff + 1'b1) : wp_ff;
        nxt_rp = pop ? PW'(rp_ff + 1'b1) : rp_ff;
        nxt_cnt = cnt_ff;
        if (push && !pop)
            nxt_cnt = cnt_ff + 1'b1;
        else if (pop && !push)
            nxt_cnt = cnt_ff - 1'b1;
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wp_ff <= '0;
            rp_ff <= '0;
            cnt_ff <= '0;
        end
        else
        begin
            wp_ff <= nxt_wp;
            rp_ff <= nxt_rp;
            cnt_ff <= nxt_cnt;
        end
    end

    // storage needs no reset; words are only read once counted in
    always_ff @(posedge ref_clk_i)
    begin
        if (push)
            mem_ff[wp_ff] <= in_data_i;
    end
endmodule : prog_fifo
`default_nettype wire

// File: verilog/eeprom_slave.sv
// two-wire serial memory slave: page buffer, write cycle, reads
//
// Operation
// - one write transaction carries 1..128 data bytes for one page.
// - on STOP after a write, all buffered bytes go to the array.
// - more than 128 bytes wrap the buffer, overwriting the earliest.
// - write pointer wraps to first byte of the same page.
// - no acknowledge to control byte while write cycle runs.
// - first byte at start address, each next at page-bounded next address.
// - with write lock high all bytes acked, nothing stored, no busy.
// - blocked write still loads and advances pointer within the page.
// - bytes programmed one by one, time scales with byte count.
// - write lock sampled at STOP, later changes ignored.
// - write lock high blocks the whole array, low permits writes.
// - direction bit one selects read; current, random, sequential reads.
// - pointer is last address plus one, rolls over to zero.
// - read control byte acked, byte at pointer sent, stop on nack.
// - random read: address write, repeated START keeps pointer loaded.
// - after random read pointer sits after the returned byte.
// - master ack fetches next byte; nack then STOP ends the read.
// - read pointer advances on each master ack and on the STOP or START after a nack.
// - respond only to control code 1010 and matching strap levels.
// - high then low address byte follow a write control byte.
// - write cycle only on STOP; otherwise array unchanged.
// - each byte programming step ends within the byte write time.
`timescale 1ns/1ps
`default_nettype none
module eeprom_slave #(
    parameter int BYTE_CYCLES = eeprom_pkg::BYTE_WRITE_CYCLES
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic write_lock_i,
    input wire logic chip_select_strap_0_i,
    input wire logic chip_select_strap_1_i,
    input wire logic chip_select_strap_2_i,
    output logic [eeprom_pkg::ADDR_W-1:0] mem_raddr_o,
    input wire logic [7:0] mem_rdata_i,
    output logic mem_we_o,
    output logic [eeprom_pkg::ADDR_W-1:0] mem_waddr_o,
    output logic [7:0] mem_wdata_o,
    output logic busy_o
);
    import eeprom_pkg::*;

    // pin synchronisers; stage a is read only by stage b
    logic [5:0] sync_a_ff, sync_b_ff;
    logic scl_d_ff, sda_d_ff;
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sync_a_ff <= 6'h03;
            sync_b_ff <= 6'h03;
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
        end
        else
        begin
            sync_a_ff <= {chip_select_strap_2_i, chip_select_strap_1_i, chip_select_strap_0_i,
                          write_lock_i, sda_i, scl_i};
            sync_b_ff <= sync_a_ff;
            scl_d_ff <= sync_b_ff[0];
            sda_d_ff <= sync_b_ff[1];
        end
    end

    logic scl_s, sda_s, lock_s;
    logic [2:0] strap_s;
    logic scl_rise, scl_fall, start_det, stop_det;
    assign scl_s = sync_b_ff[0];
    assign sda_s = sync_b_ff[1];
    assign lock_s = sync_b_ff[2];
    assign strap_s = sync_b_ff[5:3];
    assign scl_rise = scl_s && !scl_d_ff;
    assign scl_fall = !scl_s && scl_d_ff;
    assign start_det = scl_s && scl_d_ff && sda_d_ff && !sda_s;
    assign stop_det = scl_s && scl_d_ff && !sda_d_ff && sda_s;

    // link state
    link_st_t st_ff, nxt_st;
    logic [3:0] bit_ff, nxt_bit;
    logic [7:0] sh_ff, nxt_sh, hi_ff, nxt_hi;
    logic [15:0] ptr_ff, nxt_ptr, start_ff, nxt_start;
    logic [7:0] cnt_ff, nxt_cnt;
    logic [IDX_W-1:0] widx_ff, nxt_widx;
    logic oe_ff, nxt_oe, rnw_ff, nxt_rnw, rdpend_ff, nxt_rdpend;
    logic buf_we, commit_go, busy, ctrl_match;

    assign ctrl_match = (sh_ff[7:4] == CTRL_CODE) && (sh_ff[3:1] == strap_s);

    always_comb
    begin
        nxt_st = st_ff;
        nxt_bit = bit_ff;
        nxt_sh = sh_ff;
        nxt_hi = hi_ff;
        nxt_ptr = ptr_ff;
        nxt_start = start_ff;
        nxt_cnt = cnt_ff;
        nxt_widx = widx_ff;
        nxt_oe = oe_ff;
        nxt_rnw = rnw_ff;
        nxt_rdpend = rdpend_ff;
        buf_we = 1'b0;
        commit_go = 1'b0;
        if (start_det)
        begin
            // repeated START drops a pending write, pointer stays loaded unless a read ended in a nack
            if (rdpend_ff)
                nxt_ptr = ptr_ff + 16'h0001;
            nxt_st = ST_CTRL;
            // the START's own scl fall wraps this to zero, so it is not counted as a bit
            nxt_bit = '1;
            nxt_oe = 1'b0;
            nxt_cnt = '0;
            nxt_widx = '0;
            nxt_rdpend = 1'b0;
        end
        else if (stop_det)
        begin
            // lock sampled here only; a locked write leaves busy clear
            if (st_ff == ST_WDATA && cnt_ff != '0 && !lock_s)
                commit_go = 1'b1;
            if (rdpend_ff)
                nxt_ptr = ptr_ff + 16'h0001;
            nxt_st = ST_IDLE;
            nxt_oe = 1'b0;
            nxt_rdpend = 1'b0;
        end
        else if (scl_rise && st_ff != ST_IDLE && st_ff != ST_SKIP)
        begin
            if (st_ff != ST_RDATA && bit_ff != ACK_BIT)
                nxt_sh = {sh_ff[6:0], sda_s};
            else if (st_ff == ST_RDATA && bit_ff == ACK_BIT)
            begin
                if (!sda_s)
                    nxt_ptr = ptr_ff + 16'h0001;
                else
                begin
                    nxt_rdpend = 1'b1;
                    nxt_st = ST_SKIP;
                end
            end
        end
        else if (scl_fall && st_ff != ST_IDLE && st_ff != ST_SKIP)
        begin
            if (bit_ff == LAST_BIT)
            begin
                nxt_bit = ACK_BIT;
                nxt_oe = (st_ff != ST_RDATA);
                unique case (st_ff)
                    ST_CTRL:
                    begin
                        nxt_rnw = sh_ff[0];
                        if (!ctrl_match || busy)
                        begin
                            nxt_oe = 1'b0;
                            nxt_st = ST_SKIP;
                        end
                    end
                    ST_ADDRH:
                        nxt_hi = sh_ff;
                    ST_ADDRL:
                    begin
                        nxt_ptr = {hi_ff, sh_ff};
                        nxt_start = {hi_ff, sh_ff};
                    end
                    ST_WDATA:
                    begin
                        buf_we = 1'b1;
                        nxt_widx = IDX_W'(widx_ff + 1'b1);
                        nxt_cnt = (cnt_ff == PAGE_BYTES) ? PAGE_BYTES : cnt_ff + 8'h01;
                        nxt_ptr = {ptr_ff[15:7], 7'(ptr_ff[6:0] + 7'h01)};
                    end
                    default:
                        nxt_oe = 1'b0;
                endcase
            end
            else if (bit_ff == ACK_BIT)
            begin
                nxt_bit = '0;
                nxt_oe = 1'b0;
                if ((st_ff == ST_CTRL && rnw_ff) || st_ff == ST_RDATA)
                begin
                    // array data settled long before this edge
                    nxt_st = ST_RDATA;
                    nxt_sh = mem_rdata_i;
                    nxt_oe = !mem_rdata_i[7];
                end
                else if (st_ff == ST_CTRL)
                    nxt_st = ST_ADDRH;
                else if (st_ff == ST_ADDRH)
                    nxt_st = ST_ADDRL;
                else
                    nxt_st = ST_WDATA;
            end
            else
            begin
                nxt_bit = bit_ff + 4'h1;
                if (st_ff == ST_RDATA)
                begin
                    nxt_sh = {sh_ff[6:0], 1'b0};
                    nxt_oe = !sh_ff[6];
                end
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            st_ff <= ST_IDLE;
            bit_ff <= '0;
            sh_ff <= '0;
            hi_ff <= '0;
            ptr_ff <= PTR_RST;
            start_ff <= PTR_RST;
            cnt_ff <= '0;
            widx_ff <= '0;
            oe_ff <= 1'b0;
            rnw_ff <= 1'b0;
            rdpend_ff <= 1'b0;
        end
        else
        begin
            st_ff <= nxt_st;
            bit_ff <= nxt_bit;
            sh_ff <= nxt_sh;
            hi_ff <= nxt_hi;
            ptr_ff <= nxt_ptr;
            start_ff <= nxt_start;
            cnt_ff <= nxt_cnt;
            widx_ff <= nxt_widx;
            oe_ff <= nxt_oe;
            rnw_ff <= nxt_rnw;
            rdpend_ff <= nxt_rdpend;
        end
    end

    // page buffer
    logic [7:0] buf_ff [PAGE_BYTES];
    always_ff @(posedge ref_clk_i)
    begin
        if (buf_we)
            buf_ff[widx_ff] <= sh_ff;
    end

    // commit engine feeds the programming fifo; fifo back-pressure stalls it
    logic commit_ff, nxt_commit, fifo_in_ready, fifo_out_valid, fifo_out_ready;
    logic [IDX_W-1:0] cidx_ff, nxt_cidx;
    logic [7:0] ccnt_ff, nxt_ccnt;
    logic [FIFO_W-1:0] fifo_in_data, fifo_out_data;
    assign fifo_in_data = {start_ff[15:7], 7'(start_ff[6:0] + cidx_ff), buf_ff[cidx_ff]};

    always_comb
    begin
        nxt_commit = commit_ff;
        nxt_cidx = cidx_ff;
        nxt_ccnt = ccnt_ff;
        if (commit_go)
        begin
            nxt_commit = 1'b1;
            nxt_cidx = '0;
            nxt_ccnt = cnt_ff;
        end
        else if (commit_ff && fifo_in_ready)
        begin
            nxt_cidx = IDX_W'(cidx_ff + 1'b1);
            if (8'({1'b0, cidx_ff} + 8'h01) == ccnt_ff)
                nxt_commit = 1'b0;
        end
    end

    // programming side: one byte per timer period
    logic [TIMER_W-1:0] timer_ff, nxt_timer;
    logic we_ff, nxt_we;
    logic [15:0] waddr_ff, nxt_waddr;
    logic [7:0] wdata_ff, nxt_wdata;
    assign fifo_out_ready = (timer_ff == '0);

    always_comb
    begin
        nxt_we = 1'b0;
        nxt_waddr = waddr_ff;
        nxt_wdata = wdata_ff;
        nxt_timer = (timer_ff != '0) ? timer_ff - 1'b1 : timer_ff;
        if (fifo_out_valid && fifo_out_ready)
        begin
            nxt_we = 1'b1;
            nxt_waddr = fifo_out_data[23:8];
            nxt_wdata = fifo_out_data[7:0];
            nxt_timer = TIMER_W'(BYTE_CYCLES - 1);
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            commit_ff <= 1'b0;
            cidx_ff <= '0;
            ccnt_ff <= '0;
            timer_ff <= '0;
            we_ff <= 1'b0;
            waddr_ff <= '0;
            wdata_ff <= '0;
        end
        else
        begin
            commit_ff <= nxt_commit;
            cidx_ff <= nxt_cidx;
            ccnt_ff <= nxt_ccnt;
            timer_ff <= nxt_timer;
            we_ff <= nxt_we;
            waddr_ff <= nxt_waddr;
            wdata_ff <= nxt_wdata;
        end
    end

    prog_fifo #(
        .WIDTH(FIFO_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .in_valid_i(commit_ff),
        .in_ready_o(fifo_in_ready),
        .in_data_i(fifo_in_data),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_out_ready),
        .out_data_o(fifo_out_data)
    );

    assign busy = commit_ff || fifo_out_valid || (timer_ff != '0);
    assign busy_o = busy;
    assign sda_o = 1'b0;
    assign sda_oe_o = oe_ff;
    assign mem_raddr_o = ptr_ff;
    assign mem_we_o = we_ff;
    assign mem_waddr_o = waddr_ff;
    assign mem_wdata_o = wdata_ff;

    // checks
    logic ctrl_ack;
    assign ctrl_ack = scl_fall && st_ff == ST_CTRL && bit_ff == LAST_BIT;
    a_busy_noack: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        ctrl_ack && busy |=> !oe_ff && st_ff == ST_SKIP) else $error("acked while busy");
    a_match_ack: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        ctrl_ack && !busy && ctrl_match |=> oe_ff) else $error("matching control byte not acked");
    a_bad_ctrl: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        ctrl_ack && !ctrl_match |=> st_ff == ST_SKIP && !oe_ff) else $error("foreign control byte acked");
    a_lock_nowrite: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        stop_det && st_ff == ST_WDATA && lock_s && !busy |=> !busy) else $error("locked write started cycle");
    a_stop_commit: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        stop_det && st_ff == ST_WDATA && !lock_s && cnt_ff != '0 |=> commit_ff && ccnt_ff == $past(cnt_ff))
        else $error("stop did not start commit");
    a_rstart_nowrite: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        start_det && st_ff == ST_WDATA && !busy |=> !commit_ff && cnt_ff == '0) else $error("write without stop");
    a_page_wrap: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        buf_we |=> ptr_ff[15:7] == $past(ptr_ff[15:7]) && ptr_ff[6:0] == 7'($past(ptr_ff[6:0]) + 7'h01))
        else $error("write pointer left page");
    a_read_inc: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        scl_rise && st_ff == ST_RDATA && bit_ff == ACK_BIT && !sda_s |=> ptr_ff == 16'($past(ptr_ff) + 16'h0001))
        else $error("read pointer not advanced");
    a_byte_spacing: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        we_ff |=> !we_ff [*8]) else $error("array writes too close");
    a_cnt_bound: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        cnt_ff <= PAGE_BYTES) else $error("buffer count over page");
    c_page_write: cover property (@(posedge ref_clk_i) disable iff (rst_i) commit_go && cnt_ff > 8'h01);
    c_seq_read: cover property (@(posedge ref_clk_i) disable iff (rst_i)
        scl_rise && st_ff == ST_RDATA && bit_ff == ACK_BIT && !sda_s);
    c_busy_poll: cover property (@(posedge ref_clk_i) disable iff (rst_i) ctrl_ack && busy && ctrl_match);
    c_locked: cover property (@(posedge ref_clk_i) disable iff (rst_i) stop_det && st_ff == ST_WDATA && lock_s);
endmodule : eeprom_slave
`default_nettype wire

// File: testbench/i2c_master_model.sv
// bus master model driving the two-wire link
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
    output logic scl_o,
    output logic sda_drv_o,
    input wire logic sda_i
);
    // quarter of a 125 ns link clock; scl stands still between frames
    localparam realtime QTR = 31.25;
    initial
    begin
        scl_o = 1'b1;
        sda_drv_o = 1'b1;
    end
    task automatic start_cond();
        #QTR sda_drv_o = 1'b1;
        #QTR scl_o = 1'b1;
        #QTR sda_drv_o = 1'b0;
        #QTR scl_o = 1'b0;
    endtask : start_cond
    task automatic stop_cond();
        #QTR sda_drv_o = 1'b0;
        #QTR scl_o = 1'b1;
        #QTR sda_drv_o = 1'b1;
        #QTR;
    endtask : stop_cond
    // data moves only while scl is low
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--)
        begin
            #QTR sda_drv_o = b[i];
            #QTR scl_o = 1'b1;
            #(2*QTR) scl_o = 1'b0;
        end
        #QTR sda_drv_o = 1'b1;
        #QTR scl_o = 1'b1;
        #QTR ack = ~sda_i;
        #QTR scl_o = 1'b0;
    endtask : send_byte
    // sda is already released by the byte or ack that came before
    task automatic recv_byte(input logic give_ack, output logic [7:0] b);
        for (int i = 7; i >= 0; i--)
        begin
            #(2*QTR) scl_o = 1'b1;
            #QTR b[i] = sda_i;
            #QTR scl_o = 1'b0;
        end
        #QTR sda_drv_o = ~give_ack;
        #QTR scl_o = 1'b1;
        #(2*QTR) scl_o = 1'b0;
        #QTR sda_drv_o = 1'b1;
    endtask : recv_byte
endmodule : i2c_master_model
`default_nettype wire

// File: testbench/testbench.sv
// self-checking bench of the serial memory slave
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import eeprom_pkg::*;
    localparam int BC = 40;
    localparam int TIMEOUT_CYC = 60000;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic lock = 1'b0;
    logic [2:0] straps = 3'b101;
    logic [7:0] mem_rdata = 8'h00;
    wire scl;
    wire sda_drv;
    wire sda_oe;
    wire sda_lvl;
    wire mem_we;
    wire busy;
    wire [ADDR_W-1:0] mem_raddr;
    wire [ADDR_W-1:0] mem_waddr;
    wire [7:0] mem_wdata;
    // open drain with pull-up: released line reads high
    wire sda = sda_drv & (sda_oe ? sda_lvl : 1'b1);
    logic [7:0] mem [0:65535];
    int error_cnt = 0;
    int samples_checked = 0;
    int cyc = 0;
    int we_cnt = 0;
    int last_we = 0;
    int we_gap = 0;

    eeprom_slave #(.BYTE_CYCLES(BC)) i_eeprom_slave (.ref_clk_i(ref_clk), .rst_i(rst), .scl_i(scl),
        .sda_i(sda), .sda_o(sda_lvl), .sda_oe_o(sda_oe), .write_lock_i(lock), .chip_select_strap_0_i(straps[0]),
        .chip_select_strap_1_i(straps[1]), .chip_select_strap_2_i(straps[2]), .mem_raddr_o(mem_raddr),
        .mem_rdata_i(mem_rdata), .mem_we_o(mem_we), .mem_waddr_o(mem_waddr), .mem_wdata_o(mem_wdata),
        .busy_o(busy));
    i2c_master_model i_i2c_master_model (.scl_o(scl), .sda_drv_o(sda_drv), .sda_i(sda));

    initial
    begin
        forever #4 ref_clk = ~ref_clk;
    end
    always @(negedge ref_clk) mem_rdata <= mem[mem_raddr];
    always @(posedge ref_clk)
    begin
        cyc++;
        if (mem_we === 1'b1)
        begin
            mem[mem_waddr] = mem_wdata;
            we_cnt++;
            we_gap = cyc - last_we;
            last_we = cyc;
        end
        if (cyc == TIMEOUT_CYC)
        begin
            error_cnt++;
            report_and_stop();
        end
    end

    function automatic logic [7:0] pat(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5a;
    endfunction : pat
    function automatic logic [7:0] ctrl(input logic rd);
        return {CTRL_CODE, straps, rd};
    endfunction : ctrl
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_byte
    task automatic check_num(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_num
    task automatic send_chk(input logic [7:0] b, input logic exp_ack);
        logic ack;
        i_i2c_master_model.send_byte(b, ack);
        check_num({31'h0, ack}, {31'h0, exp_ack});
    endtask : send_chk
    task automatic wr_hdr(input logic [15:0] a);
        i_i2c_master_model.start_cond();
        send_chk(ctrl(1'b0), 1'b1);
        send_chk(a[15:8], 1'b1);
        send_chk(a[7:0], 1'b1);
    endtask : wr_hdr
    task automatic cur_read(input logic [7:0] exp);
        logic [7:0] b;
        i_i2c_master_model.start_cond();
        send_chk(ctrl(1'b1), 1'b1);
        i_i2c_master_model.recv_byte(1'b0, b);
        i_i2c_master_model.stop_cond();
        check_byte(b, exp);
    endtask : cur_read
    task automatic wait_idle();
        for (int i = 0; i < 8000 && busy !== 1'b0; i++)
            @(negedge ref_clk);
    endtask : wait_idle

    task automatic t_page_write();
        logic [15:0] a;
        logic ack;
        int nacks;
        int w0;
        a = 16'h127c;
        nacks = 0;
        ack = 1'b0;
        w0 = we_cnt;
        wr_hdr(a);
        for (int k = 0; k < 6; k++)
            send_chk(8'ha0 + k[7:0], 1'b1);
        i_i2c_master_model.stop_cond();
        repeat (4) @(negedge ref_clk);
        check_num({31'h0, busy}, 32'h1);
        for (int i = 0; i < 60 && ack !== 1'b1; i++)
        begin
            i_i2c_master_model.start_cond();
            i_i2c_master_model.send_byte(ctrl(1'b0), ack);
            if (ack !== 1'b1)
                nacks++;
        end
        i_i2c_master_model.stop_cond();
        check_num({31'h0, nacks > 0}, 32'h1);
        check_num({31'h0, ack}, 32'h1);
        check_num(we_cnt - w0, 32'h6);
        check_num(we_gap, BC);
        for (int k = 0; k < 6; k++)
            check_byte(mem[{a[15:7], a[6:0] + k[6:0]}], 8'ha0 + k[7:0]);
        $display("test page_write done");
    endtask : t_page_write

    task automatic t_buffer_wrap();
        int w0;
        w0 = we_cnt;
        wr_hdr(16'h0300);
        for (int k = 0; k < 130; k++)
            send_chk(k[7:0], 1'b1);
        i_i2c_master_model.stop_cond();
        wait_idle();
        check_num(we_cnt - w0, 32'd128);
        check_byte(mem[16'h0300], 8'h80);
        check_byte(mem[16'h0301], 8'h81);
        check_byte(mem[16'h0302], 8'h02);
        check_byte(mem[16'h037f], 8'h7f);
        $display("test buffer_wrap done");
    endtask : t_buffer_wrap

    task automatic t_locked();
        int w0;
        w0 = we_cnt;
        @(negedge ref_clk) lock = 1'b1;
        wr_hdr(16'h047e);
        for (int k = 0; k < 3; k++)
            send_chk(8'hc0 + k[7:0], 1'b1);
        i_i2c_master_model.stop_cond();
        @(negedge ref_clk) lock = 1'b0;
        repeat (8) @(negedge ref_clk);
        check_num({31'h0, busy}, 32'h0);
        cur_read(pat(16'h0401));
        check_num(we_cnt - w0, 32'h0);
        check_byte(mem[16'h047e], pat(16'h047e));
        $display("test locked_write done");
    endtask : t_locked

    task automatic t_random_seq();
        logic [7:0] b;
        wr_hdr(16'hfffe);
        i_i2c_master_model.start_cond();
        send_chk(ctrl(1'b1), 1'b1);
        i_i2c_master_model.recv_byte(1'b1, b);
        check_byte(b, pat(16'hfffe));
        i_i2c_master_model.recv_byte(1'b1, b);
        check_byte(b, pat(16'hffff));
        i_i2c_master_model.recv_byte(1'b0, b);
        check_byte(b, pat(16'h0000));
        i_i2c_master_model.stop_cond();
        cur_read(pat(16'h0001));
        $display("test random_sequential done");
    endtask : t_random_seq

    task automatic t_refused();
        int w0;
        w0 = we_cnt;
        wr_hdr(16'h0500);
        send_chk(8'h55, 1'b1);
        i_i2c_master_model.start_cond();
        send_chk({4'hb, straps, 1'b0}, 1'b0);
        send_chk(8'h00, 1'b0);
        i_i2c_master_model.stop_cond();
        i_i2c_master_model.start_cond();
        send_chk({CTRL_CODE, straps ^ 3'h2, 1'b1}, 1'b0);
        i_i2c_master_model.stop_cond();
        repeat (8) @(negedge ref_clk);
        check_num(we_cnt - w0, 32'h0);
        check_byte(mem[16'h0500], pat(16'h0500));
        $display("test refused done");
    endtask : t_refused

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : report_and_stop

    initial
    begin
        for (int a = 0; a < 65536; a++)
            mem[a] = pat(a[15:0]);
        repeat (16) @(negedge ref_clk);
        rst = 1'b0;
        repeat (6) @(negedge ref_clk);
        t_page_write();
        t_buffer_wrap();
        t_locked();
        t_random_seq();
        t_refused();
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
